//--- hw/tlend_pkg.sv
// tlend_pkg: constants, types and register map of the telegram end and level block.
// assumes a host reaches the registers through the block's byte-wide register port.
package tlend_pkg;

  // register offsets
  localparam logic [7:0] TLEND_OFS_PAT_LO_A  = 8'h88;
  localparam logic [7:0] TLEND_OFS_PAT_HI_A  = 8'h89;
  localparam logic [7:0] TLEND_OFS_CTRL_A    = 8'h8A;
  localparam logic [7:0] TLEND_OFS_LEN_A     = 8'h8B;
  localparam logic [7:0] TLEND_OFS_PAT_LO_B  = 8'hA8;
  localparam logic [7:0] TLEND_OFS_PAT_HI_B  = 8'hA9;
  localparam logic [7:0] TLEND_OFS_CTRL_B    = 8'hAA;
  localparam logic [7:0] TLEND_OFS_LEN_B     = 8'hAB;
  localparam logic [7:0] TLEND_OFS_PEAK      = 8'hAC;
  localparam logic [7:0] TLEND_OFS_FSK_NOISE = 8'hAF;
  localparam logic [7:0] TLEND_OFS_ASK_NOISE = 8'hB0;

  // end control fields
  localparam int TLEND_BIT_END_LEN  = 0;
  localparam int TLEND_BIT_END_CV   = 1;
  localparam int TLEND_BIT_END_SYNC = 2;

  // reset values and widths
  localparam logic [7:0]  TLEND_RST_BYTE    = 8'h00;
  localparam logic [15:0] TLEND_RST_PATTERN = 16'h0000;
  localparam int          TLEND_PAT_CHIPS   = 16;
  localparam int          TLEND_LEN_W       = 5;
  localparam int          TLEND_ASK_W       = 6;
  localparam logic [1:0]  TLEND_MODE_16BIT  = 2'h0;
  localparam logic [7:0]  TLEND_CNT_MAX     = 8'hFF;

  typedef enum logic [1:0] {
    TLEND_IDLE    = 2'b00,
    TLEND_HUNT_B  = 2'b01,
    TLEND_PAYLOAD = 2'b10
  } tlend_state_t;

  // one payload bit on its way to the receiver
  typedef struct packed {
    logic data;
    logic last;
  } tlend_word_t;

  // one configuration set
  typedef struct packed {
    logic [15:0] pattern;
    logic [7:0]  ctrl;
    logic [7:0]  limit;
  } tlend_cfg_t;

endpackage

//--- hw/tlend_top.sv
// tlend_top: start pattern b match, end of message decision, peak level and noise readout.
// assumes all inputs are synchronous to core_clk; first pattern match comes from outside.
`timescale 1ns/1ps
`default_nettype none
module tlend_top
  import tlend_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  // clock and reset
  input  wire  logic                   core_clk,
  input  wire  logic                   rst,
  // register port
  input  wire  logic [7:0]             reg_addr,
  input  wire  logic [7:0]             reg_wdata,
  input  wire  logic                   reg_wr,
  input  wire  logic                   reg_rd,
  output logic [7:0]                   reg_rdata,
  // receiver configuration
  input  wire  logic                   cfg_set_sel,
  input  wire  logic [1:0]             detect_mode,
  input  wire  logic [TLEND_LEN_W-1:0] pattern_b_length,
  input  wire  logic [7:0]             peak_start_offset,
  // chip stream and receiver events
  input  wire  logic                   chip_valid,
  input  wire  logic                   chip_in,
  input  wire  logic                   start_a_found,
  input  wire  logic                   sync_lost,
  input  wire  logic                   code_violation,
  // decoded bit stream in
  input  wire  logic                   in_valid,
  input  wire  logic                   in_bit,
  output logic                         in_ready,
  // payload stream out
  output logic                         out_valid,
  output tlend_pkg::tlend_word_t       out_word,
  input  wire  logic                   out_ready,
  // levels
  input  wire  logic                   level_valid,
  input  wire  logic [7:0]             level_sample,
  input  wire  logic [7:0]             fsk_noise,
  input  wire  logic [TLEND_ASK_W-1:0] ask_noise,
  // events
  output logic                         frame_sync_event,
  output logic                         end_of_message
);
  import tlend_pkg::*;

  // bit mask covering the newest len chips
  function automatic logic [15:0] chip_mask(input logic [TLEND_LEN_W-1:0] len);
    logic [16:0] m;
    m = (17'h00001 << len) - 17'h00001;
    return m[15:0];
  endfunction

  // registers
  tlend_cfg_t   cfg_a_reg, cfg_b_reg;
  tlend_state_t state_reg, state_next;
  logic [15:0]  chips_reg;
  logic [TLEND_LEN_W-1:0] chip_cnt_reg;
  logic [7:0]   bit_cnt_reg;
  logic [7:0]   peak_reg;
  logic         peak_track_reg;
  logic         sync_reg, eom_reg;
  tlend_word_t  buf_mem [DEPTH];
  logic         wr_ptr_reg, rd_ptr_reg;
  logic [1:0]   fill_reg;

  // register writes; each set keeps its own end control
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_a_reg <= '{TLEND_RST_PATTERN, TLEND_RST_BYTE, TLEND_RST_BYTE};
      cfg_b_reg <= '{TLEND_RST_PATTERN, TLEND_RST_BYTE, TLEND_RST_BYTE};
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        TLEND_OFS_PAT_LO_A: cfg_a_reg.pattern[7:0]  <= reg_wdata;
        TLEND_OFS_PAT_HI_A: cfg_a_reg.pattern[15:8] <= reg_wdata;
        TLEND_OFS_CTRL_A:   cfg_a_reg.ctrl          <= reg_wdata;
        TLEND_OFS_LEN_A:    cfg_a_reg.limit         <= reg_wdata;
        TLEND_OFS_PAT_LO_B: cfg_b_reg.pattern[7:0]  <= reg_wdata;
        TLEND_OFS_PAT_HI_B: cfg_b_reg.pattern[15:8] <= reg_wdata;
        TLEND_OFS_CTRL_B:   cfg_b_reg.ctrl          <= reg_wdata;
        TLEND_OFS_LEN_B:    cfg_b_reg.limit         <= reg_wdata;
        default: ;
      endcase
    end
  end

  // selected configuration
  // the set select should only move between frames; a change mid-frame acts at once
  tlend_cfg_t cfg;
  assign cfg = cfg_set_sel ? cfg_b_reg : cfg_a_reg;

  // read path; write-only registers read as zero
  wire [7:0] rd_mux =
    (reg_addr == TLEND_OFS_PEAK)      ? peak_reg :
    (reg_addr == TLEND_OFS_FSK_NOISE) ? fsk_noise :
    (reg_addr == TLEND_OFS_ASK_NOISE) ? {2'h0, ask_noise} :
    TLEND_RST_BYTE;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= TLEND_RST_BYTE;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end

  // second pattern compare over the newest chips
  // the chip count stops once enough chips are in, so a long preamble cannot wrap it
  wire [15:0] chips_next = {chips_reg[14:0], chip_in};
  wire [15:0] b_mask     = chip_mask(pattern_b_length);
  wire        b_unused   = (pattern_b_length == '0);
  wire        mode_16    = (detect_mode == TLEND_MODE_16BIT);
  wire        enough     = (chip_cnt_reg >= pattern_b_length - 5'h01);
  wire        b_match    = chip_valid && enough &&
                           ((chips_next & b_mask) == (cfg.pattern & b_mask));

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      chips_reg <= TLEND_RST_PATTERN;
    else if (chip_valid)
      chips_reg <= chips_next;
  end

  // buffer handshakes; receiver stall back-pressures the bit source
  wire buf_full  = (fill_reg == 2'(DEPTH));
  wire buf_empty = (fill_reg == 2'h0);
  assign in_ready  = (state_reg == TLEND_PAYLOAD) && !buf_full;
  assign out_valid = !buf_empty;
  assign out_word  = buf_mem[rd_ptr_reg];
  wire take  = in_valid && in_ready;
  wire drain = out_valid && out_ready;

  // end of message criteria, any combination, earliest wins
  // sync loss and code violation bypass the buffer, so a stalled receiver cannot delay them
  wire in_payload = (state_reg == TLEND_PAYLOAD);
  wire len_hit  = take && cfg.ctrl[TLEND_BIT_END_LEN] &&
                  (bit_cnt_reg == cfg.limit);
  wire sync_hit = in_payload && sync_lost && cfg.ctrl[TLEND_BIT_END_SYNC];
  wire cv_hit   = in_payload && code_violation &&
                  cfg.ctrl[TLEND_BIT_END_CV];
  wire eom_hit  = len_hit || sync_hit || cv_hit;
  wire sync_hit_now = (state_reg == TLEND_HUNT_B) ? (b_unused || b_match)
                    : (state_reg == TLEND_IDLE) && start_a_found && !mode_16;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TLEND_IDLE:
        if (start_a_found)
          state_next = mode_16 ? TLEND_HUNT_B : TLEND_PAYLOAD;
      TLEND_HUNT_B:
        if (b_unused || b_match)
          state_next = TLEND_PAYLOAD;
      TLEND_PAYLOAD:
        if (eom_hit)
          state_next = TLEND_IDLE;
      default:
        state_next = TLEND_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg    <= TLEND_IDLE;
      chip_cnt_reg <= '0;
      sync_reg     <= 1'b0;
      eom_reg      <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      sync_reg  <= sync_hit_now;
      eom_reg   <= eom_hit;
      if (state_reg != TLEND_HUNT_B)
        chip_cnt_reg <= '0;
      else if (chip_valid && !enough)
        chip_cnt_reg <= chip_cnt_reg + 5'h01;
    end
  end
  assign frame_sync_event = sync_reg;
  assign end_of_message   = eom_reg;

  // payload bit count from the first bit after the pattern, saturating
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      bit_cnt_reg <= TLEND_RST_BYTE;
    else if (!in_payload)
      bit_cnt_reg <= TLEND_RST_BYTE;
    else if (take && bit_cnt_reg != TLEND_CNT_MAX)
      bit_cnt_reg <= bit_cnt_reg + 8'h01;
  end

  // two-entry buffer; the length-ending bit carries the last mark
  // two entries take one more bit while out_ready is low; the bit source then stalls a cycle while the full buffer drains
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg   <= 2'h0;
      for (int i = 0; i < DEPTH; i++)
        buf_mem[i] <= '0;
    end
    else
    begin
      if (take)
      begin
        buf_mem[wr_ptr_reg] <= '{in_bit, len_hit};
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (drain)
        rd_ptr_reg <= ~rd_ptr_reg;
      fill_reg <= fill_reg + {1'b0, take} - {1'b0, drain};
    end
  end

  // peak level: armed after frame sync plus offset, frozen by end of message
  // a sample in the ending cycle still counts; the freeze acts from the next cycle
  wire peak_arm = in_payload && !peak_track_reg && !eom_hit &&
                  (bit_cnt_reg >= peak_start_offset);
  wire peak_upd = peak_track_reg && level_valid && (level_sample > peak_reg);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      peak_reg       <= TLEND_RST_BYTE;
      peak_track_reg <= 1'b0;
    end
    else
    begin
      if (eom_hit || !in_payload)
        peak_track_reg <= 1'b0;
      else if (peak_arm)
        peak_track_reg <= 1'b1;
      if (peak_upd)
        peak_reg <= level_sample;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_len_bit;
    take && cfg.ctrl[TLEND_BIT_END_LEN] && bit_cnt_reg == cfg.limit;
  endsequence

  sequence s_pattern_b_seen;
    state_reg == TLEND_HUNT_B && (b_unused || b_match);
  endsequence

  a_len_end_pulse: assert property (s_len_bit |=>
      end_of_message && state_reg == TLEND_IDLE)
    else $error("length limit reached without end of message");

  a_last_mark: assert property (s_len_bit |=>
      buf_mem[$past(wr_ptr_reg)] == {$past(in_bit), 1'b1})
    else $error("length ending bit lacks last mark");

  a_zero_limit: assert property (take && cfg.ctrl[TLEND_BIT_END_LEN] &&
      cfg.limit == TLEND_RST_BYTE && bit_cnt_reg == TLEND_RST_BYTE |=> end_of_message)
    else $error("zero limit did not end on first bit");

  a_sync_end: assert property (sync_hit |=> end_of_message && !in_payload)
    else $error("sync loss did not end message");

  a_sync_off: assert property (in_payload && sync_lost &&
      !cfg.ctrl[TLEND_BIT_END_SYNC] && !len_hit && !cv_hit |=> !end_of_message)
    else $error("disabled sync loss ended message");

  a_cv_end: assert property (cv_hit |=> end_of_message)
    else $error("code violation did not end message");

  a_cv_off: assert property (in_payload && code_violation &&
      !cfg.ctrl[TLEND_BIT_END_CV] && !len_hit && !sync_hit |=> !end_of_message)
    else $error("disabled code violation ended message");

  a_no_cause_eom: assert property (end_of_message |->
      $past(len_hit) || $past(sync_hit) || $past(cv_hit))
    else $error("end of message without enabled cause");

  a_eom_idle: assert property (end_of_message |-> state_reg == TLEND_IDLE)
    else $error("payload still open at end of message");

  a_cnt_limit: assert property (in_payload && cfg.ctrl[TLEND_BIT_END_LEN] |->
      bit_cnt_reg <= cfg.limit)
    else $error("payload count passed limit");

  a_idle_no_take: assert property (!in_payload |-> !in_ready)
    else $error("bit accepted outside payload");

  a_full_stall: assert property (fill_reg == 2'(DEPTH) |-> !in_ready)
    else $error("bit accepted into a full buffer");

  a_b_before_sync: assert property (state_reg == TLEND_HUNT_B &&
      !b_unused && !b_match |=> !frame_sync_event)
    else $error("frame sync without second pattern");

  a_b_found_sync: assert property (s_pattern_b_seen |=> frame_sync_event && in_payload)
    else $error("second pattern seen without frame sync");

  a_sync_pulse: assert property (frame_sync_event |=> !frame_sync_event)
    else $error("frame sync held longer than one cycle");

  a_peak_frozen: assert property (!peak_track_reg |=> $stable(peak_reg))
    else $error("peak changed while frozen");

  a_peak_end_freeze: assert property (end_of_message |-> !peak_track_reg)
    else $error("peak still tracking after end of message");

  a_peak_rise: assert property (peak_track_reg && level_valid &&
      level_sample > peak_reg |=> peak_reg == $past(level_sample))
    else $error("peak not replaced by larger sample");

  a_peak_start: assert property (peak_track_reg |->
      in_payload && bit_cnt_reg >= peak_start_offset)
    else $error("peak tracking before offset");

  a_ask_read: assert property (reg_rd && reg_addr == TLEND_OFS_ASK_NOISE |=>
      reg_rdata == {2'h0, $past(ask_noise)})
    else $error("ask noise readback wrong");

  a_fsk_read: assert property (reg_rd && reg_addr == TLEND_OFS_FSK_NOISE |=>
      reg_rdata == $past(fsk_noise))
    else $error("fsk noise readback wrong");

  a_pat_write: assert property (reg_wr && reg_addr == TLEND_OFS_PAT_LO_A |=>
      cfg_a_reg.pattern[7:0] == $past(reg_wdata))
    else $error("pattern low byte write lost");

  a_set_ctrl: assert property (reg_wr && reg_addr == TLEND_OFS_CTRL_B |=>
      cfg_b_reg.ctrl == $past(reg_wdata) && $stable(cfg_a_reg.ctrl))
    else $error("set b control write disturbed set a");

endmodule
`default_nettype wire

//--- test/test_telegram_end_and_level_readout.sv
// test_telegram_end_and_level_readout: self-checking bench with a queue model of the payload.
// assumes tlend_host drives the register port and the bench drives all receiver inputs.
`timescale 1ns/1ps
`default_nettype none
module test_telegram_end_and_level_readout;
  import tlend_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, cfg_set_sel = 1'b0, chip_valid = 1'b0, chip_in = 1'b0;
  logic start_a_found = 1'b0, sync_lost = 1'b0, code_violation = 1'b0, in_valid = 1'b0;
  logic in_bit = 1'b0, out_ready = 1'b0, level_valid = 1'b0;
  logic [1:0] detect_mode = 2'h1;
  logic [TLEND_LEN_W-1:0] pattern_b_length = 5'h08;
  logic [TLEND_ASK_W-1:0] ask_noise = 6'h00;
  logic [7:0] peak_start_offset = 8'h00, level_sample = 8'h00, fsk_noise = 8'h00, pat, rv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, in_ready, out_valid, frame_sync_event, end_of_message;
  tlend_word_t out_word;
  int mismatches = 0, cmp_count = 0, acc_n = 0, lim_n = -1, peak_m = 0;
  int lims[3] = '{0, 3, 255};
  logic [1:0] exp_q[$];

  initial
    forever #50 core_clk = ~core_clk;

  tlend_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  tlend_top #(.DEPTH(2)) dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg_set_sel(cfg_set_sel), .detect_mode(detect_mode), .pattern_b_length(pattern_b_length),
    .peak_start_offset(peak_start_offset), .chip_valid(chip_valid), .chip_in(chip_in),
    .start_a_found(start_a_found), .sync_lost(sync_lost), .code_violation(code_violation),
    .in_valid(in_valid), .in_bit(in_bit), .in_ready(in_ready), .out_valid(out_valid),
    .out_word(out_word), .out_ready(out_ready), .level_valid(level_valid),
    .level_sample(level_sample), .fsk_noise(fsk_noise), .ask_noise(ask_noise),
    .frame_sync_event(frame_sync_event), .end_of_message(end_of_message));

  task automatic cmpv(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmpw(input logic [1:0] e, input tlend_word_t g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD out_word expected %b seen %b", e, g);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // payload model: every accepted bit must come out once, in order
  always @(posedge core_clk)
  begin
    if (in_valid && in_ready)
    begin
      exp_q.push_back({in_bit, acc_n == lim_n});
      acc_n++;
    end
    if (out_valid && out_ready)
      cmpw(exp_q.size() ? exp_q.pop_front() : 2'bxx, out_word);
  end

  // ev 0 ends on length with disabled events pulsed, 1 on code violation, 2 on sync loss
  task automatic frame(input logic sel, input logic [1:0] mode, input int lim, input int ev);
    int k;
    cfg_set_sel   <= sel;
    detect_mode   <= mode;
    start_a_found <= 1'b1;
    @(posedge core_clk);
    start_a_found <= 1'b0;
    if (mode == TLEND_MODE_16BIT && pattern_b_length != '0)
      for (k = 7; k >= 0; k--)
      begin
        chip_valid <= 1'b1;
        chip_in    <= pat[k];
        @(posedge core_clk);
        cmpv("early_sync", 16'h0000, 16'(frame_sync_event));
      end
    chip_valid <= 1'b0;
    chip_in    <= ~pat[0];
    k = 0;
    while (frame_sync_event !== 1'b1 && k < 20)
    begin
      @(posedge core_clk);
      k++;
    end
    cmpv("frame_sync", 16'h0001, 16'(frame_sync_event));
    acc_n = 0;
    lim_n = (ev == 0) ? lim : -1;
    k = 0;
    while (end_of_message !== 1'b1 && k < 1000)
    begin
      in_valid       <= (ev == 0);
      in_bit         <= 1'($urandom);
      out_ready      <= 1'($urandom);
      level_valid    <= (ev != 0 && k > 0 && k < 5);
      level_sample   <= 8'($urandom % 255);
      code_violation <= (ev == 0) ? (k == 1) : (ev == 1 && k == 6);
      sync_lost      <= (ev == 0) ? (k == 1) : (ev == 2 && k == 6);
      @(posedge core_clk);
      if (level_valid && level_sample > peak_m)
        peak_m = level_sample;
      k++;
    end
    cmpv("end_of_message", 16'h0001, 16'(end_of_message));
    if (ev == 0)
      cmpv("bits", 16'(lim + 1), 16'(acc_n));
    in_valid       <= 1'b0;
    code_violation <= 1'b0;
    sync_lost      <= 1'b0;
    out_ready      <= 1'b1;
    // a level above any tracked one after the end must not reach the peak
    level_valid    <= 1'b1;
    level_sample   <= 8'hFF;
    repeat (8) @(posedge core_clk);
    level_valid    <= 1'b0;
    cmpv("drained", 16'h0000, 16'(exp_q.size()));
  endtask

  initial
  begin
    repeat (50000) @(posedge core_clk);
    mismatches++;
    print_verdict;
  end

  initial
  begin
    void'($urandom(32'hFF7C39F9));
    repeat (20) @(posedge core_clk);
    rst       <= 1'b0;
    fsk_noise <= 8'($urandom);
    ask_noise <= 6'($urandom);
    host.rd(TLEND_OFS_PEAK, rv);
    cmpv("peak_reset", 16'h0000, 16'(rv));
    host.rd(TLEND_OFS_FSK_NOISE, rv);
    cmpv("fsk_noise", 16'(fsk_noise), 16'(rv));
    host.rd(TLEND_OFS_ASK_NOISE, rv);
    cmpv("ask_noise", 16'({2'b00, ask_noise}), 16'(rv));
    host.wr(TLEND_OFS_PEAK, 8'h5A);
    host.rd(TLEND_OFS_PEAK, rv);
    cmpv("peak_read_only", 16'h0000, 16'(rv));
    host.wr(TLEND_OFS_PAT_LO_A, 8'hC3);
    host.rd(TLEND_OFS_PAT_LO_A, rv);
    cmpv("write_only", 16'h0000, 16'(rv));
    host.rd(8'h55, rv);
    cmpv("unmapped", 16'h0000, 16'(rv));
    host.wr(TLEND_OFS_CTRL_A, 8'h09);
    host.wr(TLEND_OFS_CTRL_B, 8'h07);
    host.wr(TLEND_OFS_LEN_B, 8'hC8);
    lims[1] = 1 + ($urandom % 6);
    foreach (lims[j])
    begin
      host.wr(TLEND_OFS_LEN_A, 8'(lims[j]));
      frame(1'b0, 2'b01, lims[j], 0);
    end
    pat = 8'($urandom);
    host.wr(TLEND_OFS_PAT_LO_A, pat);
    host.wr(TLEND_OFS_LEN_A, 8'h03);
    frame(1'b0, TLEND_MODE_16BIT, 3, 0);
    pattern_b_length <= '0;
    frame(1'b0, TLEND_MODE_16BIT, 3, 0);
    frame(1'b1, 2'b01, 0, 1);
    host.rd(TLEND_OFS_PEAK, rv);
    cmpv("peak", 16'(peak_m), 16'(rv));
    host.wr(TLEND_OFS_CTRL_B, 8'h04);
    frame(1'b1, 2'b10, 0, 2);
    host.rd(TLEND_OFS_PEAK, rv);
    cmpv("peak_kept", 16'(peak_m), 16'(rv));
    print_verdict;
  end
endmodule
`default_nettype wire

//--- test/tlend_host.sv
// tlend_host: host model that writes and reads the block's byte registers.
// assumes the block samples the register strobes on the rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module tlend_host
(
  // clock
  input  wire logic       core_clk,
  // register port
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // control bit 3 has no function, so it always goes out as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= (a[3:0] == 4'hA) ? (d & 8'hF7) : d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // read data is registered, so it is taken one cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire
